// >>> hdl/paged_read_pkg.sv
package paged_read_pkg;

    // Effective address and page register geometry
    localparam int EA_W            = 16;          // Width of a working-register pointer
    localparam int EXT_WINDOW_BIT  = 15;          // Pointer bit that opens the paged window
    localparam int OFFSET_BITS     = 15;          // Offset bits kept from the pointer
    localparam int PAGE_W          = 10;          // Stored width of the read page register
    localparam int PAGE_SPACE_BIT  = 9;           // Page bit that must be clear for paged data
    localparam int PAGE_BITS       = 9;           // Page bits joined above the offset
    localparam int XADDR_W         = 24;          // Width of the formed read address

    // Value after reset
    localparam logic [PAGE_W-1:0] PAGE_RESET = 10'h000;

    // Read latencies in instruction cycles
    localparam int LAT_W           = 2;           // Width of a latency figure
    localparam logic [LAT_W-1:0] LAT_PLAIN     = 2'h1;  // Ordinary unpaged read
    localparam logic [LAT_W-1:0] LAT_EXT       = 2'h2;  // Paged read, one extra cycle
    localparam logic [LAT_W-1:0] LAT_REP_FIRST = 2'h3;  // Early paged reads inside a repeat loop
    localparam logic [LAT_W-1:0] LAT_REP_NEXT  = 2'h1;  // Later paged reads inside a repeat loop
    localparam logic [1:0]       REP_SLOW_CNT  = 2'h2;  // Number of slow reads in a repeat loop

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } read_state_t;

endpackage

// >>> hdl/read_wait_counter.sv
`timescale 1ns/1ps

// Down counter that marks the last wait cycle of a stretched read
module read_wait_counter
    import paged_read_pkg::*;
#(
    parameter int CNT_W = LAT_W
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             load,        // Start a new wait period
    input  wire logic [CNT_W-1:0] load_value,  // Number of wait cycles to run
    output logic                  expire       // High in the final wait cycle
);

    logic [CNT_W-1:0] count_q;                 // Remaining wait cycles
    logic [CNT_W-1:0] count_d;

    // Refuse a counter too narrow to hold the longest latency
    initial begin
        if (CNT_W < LAT_W) begin
            $error("read_wait_counter: CNT_W too small for the latency figures");
        end
    end

    // Load wins over counting so a back-to-back start is never lost
    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = load_value;
        end else if (count_q != '0) begin
            count_d = count_q - 1'b1;
        end
    end

    // Register the count
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // Last cycle is the one where a single wait remains
    assign expire = (count_q == CNT_W'(1));

endmodule

// >>> hdl/paged_data_read_address_gen.sv
`timescale 1ns/1ps

// Functional notes
// [R1] Software loads page, then offset pointer first
// [R2] Window open only when pointer bit 15 set
// [R3] Join page low 9 bits above offset
// [R4] Paged read takes one extra cycle
// [R5] Repeat loop: two slow reads, then single-cycle
// [R6] Window closed: plain read, page ignored
module paged_data_read_address_gen
    import paged_read_pkg::*;
#(
    parameter int EA_WIDTH = EA_W
) (
    input  wire logic                mclk,
    input  wire logic                reset,
    // Page register write from the core's data path
    input  wire logic                page_wr_en,        // One-cycle write strobe
    input  wire logic [PAGE_W-1:0]   page_wr_data,      // New page number
    // Read request from the core
    input  wire logic                rd_req,            // Read request, held until a cycle with rd_ready high takes it
    input  wire logic [EA_WIDTH-1:0] rd_ea,             // Effective address from a working register
    input  wire logic                repeat_active,     // High while a hardware repeat loop runs
    // Results
    output logic                     rd_ready,          // Request may be taken this cycle
    output logic [XADDR_W-1:0]       rd_addr,           // Formed read address
    output logic                     rd_ext,            // Address lies in the paged space
    output logic                     rd_page_fault,     // Window opened with an unsupported page
    output logic                     rd_done,           // One-cycle pulse when the read completes
    output logic [PAGE_W-1:0]        read_page_select_register  // Current page register value
);

    // Refuse a pointer width the address former cannot serve
    initial begin
        if (EA_WIDTH != EA_W) begin
            $error("paged_data_read_address_gen: EA_WIDTH must be 16");
        end
    end

    // The joined address must exactly fill the output; a mismatch would
    // silently drop page bits or leave the top of rd_addr undriven
    initial begin
        if (XADDR_W != PAGE_BITS + OFFSET_BITS) begin
            $error("paged_data_read_address_gen: page and offset bits must fill the address");
        end
        if (PAGE_W <= PAGE_SPACE_BIT) begin
            $error("paged_data_read_address_gen: page register lacks the space bit");
        end
    end

    // Page register
    logic [PAGE_W-1:0]  page_q;
    logic [PAGE_W-1:0]  page_d;

    // Sequencer and result registers
    read_state_t        state_q;
    read_state_t        state_d;
    logic               ready_q;
    logic               ready_d;
    logic [XADDR_W-1:0] addr_q;
    logic [XADDR_W-1:0] addr_d;
    logic               ext_q;
    logic               ext_d;
    logic               fault_q;
    logic               fault_d;
    logic               done_q;
    logic               done_d;
    logic [1:0]         rep_cnt_q;          // Paged reads seen in the current repeat loop
    logic [1:0]         rep_cnt_d;

    // Per-request decode
    logic               take;               // Request accepted this cycle
    logic               window_open;        // Pointer bit selects the paged window
    logic               page_ok;            // Page lies in paged data space
    logic [LAT_W-1:0]   latency;            // Cycles this read occupies
    logic               wait_load;          // Start the wait counter
    logic [LAT_W-1:0]   wait_value;         // Wait cycles beyond the accept cycle
    logic               wait_expire;        // Final wait cycle

    // Forms the extended address from page and pointer
    function automatic logic [XADDR_W-1:0] join_addr(input logic [PAGE_W-1:0]   page,
                                                     input logic [EA_WIDTH-1:0] ea);
        join_addr = {page[PAGE_BITS-1:0], ea[OFFSET_BITS-1:0]};  // [R3]
    endfunction

    // Picks the latency for a read; inside a repeat loop only the first reads are slow
    function automatic logic [LAT_W-1:0] pick_latency(input logic       ext,
                                                      input logic       in_rep,
                                                      input logic [1:0] rep_cnt);
        if (!ext) begin
            pick_latency = LAT_PLAIN;  // [R6]
        end else if (in_rep) begin
            pick_latency = (rep_cnt < REP_SLOW_CNT) ? LAT_REP_FIRST : LAT_REP_NEXT;  // [R5]
        end else begin
            pick_latency = LAT_EXT;  // [R4]
        end
    endfunction

    // The core sets up the page before the pointer read; a write in the
    // same cycle as a request lands after that request has used the page.
    always_comb begin
        page_d = page_q;
        if (page_wr_en) begin
            page_d = page_wr_data;  // [R1]
        end
    end

    // Register the page
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            page_q <= PAGE_RESET;
        end else begin
            page_q <= page_d;
        end
    end

    // Request decode; a request while ready is low is simply not taken,
    // so the core must hold it until ready returns
    assign take        = rd_req && ready_q;
    assign window_open = rd_ea[EXT_WINDOW_BIT];  // [R2]
    assign page_ok     = !page_q[PAGE_SPACE_BIT];
    assign latency     = pick_latency(window_open && page_ok, repeat_active, rep_cnt_q);
    assign wait_load   = take && (latency != LAT_PLAIN);
    // Cannot underflow where used: the counter loads only for stretched reads
    assign wait_value  = latency - LAT_PLAIN;

    // Stretches paged reads other than the later ones in a repeat loop; plain reads finish without leaving idle
    read_wait_counter #(
        .CNT_W      (LAT_W)
    ) u_wait (
        .mclk       (mclk),
        .reset      (reset),
        .load       (wait_load),
        .load_value (wait_value),
        .expire     (wait_expire)
    );

    // Repeat loop tracking: counts paged reads, saturating once the slow ones are over.
    // Leaving the loop restarts the count so the next loop again pays the slow entry.
    always_comb begin
        rep_cnt_d = rep_cnt_q;
        if (!repeat_active) begin
            rep_cnt_d = 2'h0;
        end else if (take && window_open && page_ok && (rep_cnt_q < REP_SLOW_CNT)) begin
            rep_cnt_d = rep_cnt_q + 2'h1;  // [R5]
        end
    end

    // Register the repeat count
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rep_cnt_q <= 2'h0;
        end else begin
            rep_cnt_q <= rep_cnt_d;
        end
    end

    // Sequencer: address formed on accept, done raised after the latency
    // Address and kind are held until the next accepted request
    always_comb begin
        state_d = state_q;
        ready_d = ready_q;
        addr_d  = addr_q;
        ext_d   = ext_q;
        fault_d = 1'b0;
        done_d  = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    if (window_open && page_ok) begin
                        // Paged data read
                        addr_d = join_addr(page_q, rd_ea);  // [R3]
                        ext_d  = 1'b1;
                    end else begin
                        // Plain read; an unsupported page falls back here and is flagged
                        addr_d  = {{(XADDR_W-EA_WIDTH){1'b0}}, rd_ea};  // [R6]
                        ext_d   = 1'b0;
                        fault_d = window_open;
                    end
                    if (latency == LAT_PLAIN) begin
                        done_d = 1'b1;  // [R6]
                    end else begin
                        // Hold off further requests while the read is stretched
                        state_d = ST_WAIT;  // [R4]
                        ready_d = 1'b0;
                    end
                end
            end
            ST_WAIT: begin
                // Requests are refused for the whole stretch; ready returns with done
                if (wait_expire) begin
                    done_d  = 1'b1;  // [R4]
                    ready_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // Register sequencer state and results
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            addr_q  <= '0;
            ext_q   <= 1'b0;
            fault_q <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= ready_d;
            addr_q  <= addr_d;
            ext_q   <= ext_d;
            fault_q <= fault_d;
            done_q  <= done_d;
        end
    end

    // Outputs straight from flops
    // so the core never sees decode glitches on the address
    assign rd_ready                  = ready_q;
    assign rd_addr                   = addr_q;
    assign rd_ext                    = ext_q;
    assign rd_page_fault             = fault_q;
    assign rd_done                   = done_q;
    assign read_page_select_register = page_q;

endmodule

// >>> bench/paged_read_sva.sv
`timescale 1ns/1ps

// Read-port timing watcher for the paged address former
module paged_read_sva
    import paged_read_pkg::*;
(
    input wire logic               mclk,
    input wire logic               reset,
    input wire logic               rd_req,
    input wire logic [EA_W-1:0]    rd_ea,
    input wire logic               repeat_active,
    input wire logic               rd_ready,
    input wire logic [XADDR_W-1:0] rd_addr,
    input wire logic               rd_ext,
    input wire logic               rd_page_fault,
    input wire logic               rd_done,
    input wire logic [PAGE_W-1:0]  read_page_select_register
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Accepted requests, split by kind
    wire acc = rd_req && rd_ready;
    wire win = acc && rd_ea[EXT_WINDOW_BIT];
    wire pg  = win && !read_page_select_register[PAGE_SPACE_BIT];
    // Slow reads seen in this repeat loop; saturates so later reads stay fast
    logic [1:0] rep_q;
    logic [1:0] rep_d;
    always_comb begin
        rep_d = rep_q;
        if (!repeat_active) rep_d = 2'h0;
        else if (pg && rep_q != 2'h2) rep_d = rep_q + 2'h1;
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) rep_q <= 2'h0;
        else rep_q <= rep_d;
    end
    property p_plain;
        acc && !rd_ea[EXT_WINDOW_BIT] |=> rd_done && !rd_ext && rd_addr == {8'h00, $past(rd_ea)};
    endproperty
    a_plain: assert property (p_plain) else $error("plain read wrong");
    property p_join;
        pg |=> rd_ext && rd_addr == {$past(read_page_select_register[8:0]), $past(rd_ea[14:0])};
    endproperty
    a_join: assert property (p_join) else $error("paged address wrong");
    property p_ext_lat;
        pg && !repeat_active |=> !rd_done && !rd_ready ##1 rd_done && rd_ready;
    endproperty
    a_ext_lat: assert property (p_ext_lat) else $error("paged latency wrong");
    property p_rep_slow;
        pg && repeat_active && rep_q != 2'h2 |=> !rd_done [*2] ##1 rd_done;
    endproperty
    a_rep_slow: assert property (p_rep_slow) else $error("early repeat read not slow");
    property p_rep_fast;
        pg && repeat_active && rep_q == 2'h2 |=> rd_done;
    endproperty
    a_rep_fast: assert property (p_rep_fast) else $error("later repeat read not fast");
    property p_fault;
        win && read_page_select_register[PAGE_SPACE_BIT] |=> rd_done && rd_page_fault && !rd_ext;
    endproperty
    a_fault: assert property (p_fault) else $error("bad page not flagged");
    c_ext: cover property (pg && !repeat_active);
    c_rep: cover property (pg && repeat_active && rep_q == 2'h2);
    c_fault: cover property (win && read_page_select_register[PAGE_SPACE_BIT]);
endmodule

// >>> bench/core_model.sv
`timescale 1ns/1ps

// Stands in for the core's data-read path
module core_model
    import paged_read_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rd_ready,
    output logic              page_wr_en,
    output logic [PAGE_W-1:0] page_wr_data,
    output logic              rd_req,
    output logic [EA_W-1:0]   rd_ea,
    output logic              repeat_active
);
    // Quiet bus at time zero
    initial begin
        page_wr_en = 1'b0;
        page_wr_data = 10'h000;
        rd_req = 1'b0;
        rd_ea = 16'h0000;
        repeat_active = 1'b0;
    end
    // Page is loaded before any pointer that uses it
    task automatic set_page(input logic [PAGE_W-1:0] p);
        @(posedge mclk);
        page_wr_en <= 1'b1;
        page_wr_data <= p;
        @(posedge mclk);
        page_wr_en <= 1'b0;
        page_wr_data <= ~p;
    endtask
    task automatic set_rep(input logic v);
        @(posedge mclk);
        repeat_active <= v;
    endtask
    // Request held until taken; pointer then goes stale so no leftover is trusted
    task automatic issue(input logic [EA_W-1:0] ea);
        @(posedge mclk);
        rd_req <= 1'b1;
        rd_ea <= ea;
        do @(posedge mclk); while (rd_ready !== 1'b1);
        rd_req <= 1'b0;
        rd_ea <= ~ea;
    endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps

module testbench;
    logic        mclk, reset, page_wr_en, rd_req, repeat_active;
    logic        rd_ready, rd_ext, rd_page_fault, rd_done;
    logic [9:0]  page_wr_data, pg_q;
    logic [15:0] rd_ea;
    logic [23:0] rd_addr;
    int          mismatches, cmp_count, cyc;
    paged_data_read_address_gen dut (.mclk(mclk), .reset(reset), .page_wr_en(page_wr_en),
        .page_wr_data(page_wr_data), .rd_req(rd_req), .rd_ea(rd_ea), .repeat_active(repeat_active),
        .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_ext(rd_ext), .rd_page_fault(rd_page_fault),
        .rd_done(rd_done), .read_page_select_register(pg_q));
    core_model core (.mclk(mclk), .rd_ready(rd_ready), .page_wr_en(page_wr_en), .page_wr_data(page_wr_data),
        .rd_req(rd_req), .rd_ea(rd_ea), .repeat_active(repeat_active));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One read; address seen after the taking edge, done counted in cycles
    task automatic rd(input logic [15:0] ea, input logic [23:0] a, input logic x, f, input int lat);
        int n;
        core.issue(ea);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
            if (n == 1) check(rd_addr, a);
            if (n == 1) check(rd_ext, x);
            if (n == 1) check(rd_ready, lat == 1);
        end while (rd_done !== 1'b1 && n < 9);
        check(n, lat);
        check(rd_page_fault, f);
        check(rd_ready, 1'b1);
        // Done and fault stand for one cycle only
        @(negedge mclk);
        check(rd_done, 1'b0);
        check(rd_page_fault, 1'b0);
    endtask
    task automatic t_plain();
        check(pg_q, 10'h000);
        core.set_page(10'h002);
        rd(16'h0800, 24'h000800, 1'b0, 1'b0, 1);
        rd(16'h7fff, 24'h007fff, 1'b0, 1'b0, 1);
    endtask
    task automatic t_paged();
        rd(16'h8800, 24'h010800, 1'b1, 1'b0, 2);
        core.set_page(10'h1ff);
        @(negedge mclk);
        check(pg_q, 10'h1ff);
        rd(16'hffff, 24'hffffff, 1'b1, 1'b0, 2);
    endtask
    // Plain read between slow ones must not advance the loop count
    task automatic t_repeat();
        core.set_page(10'h003);
        core.set_rep(1'b1);
        rd(16'h8000, 24'h018000, 1'b1, 1'b0, 3);
        rd(16'h0010, 24'h000010, 1'b0, 1'b0, 1);
        rd(16'h8002, 24'h018002, 1'b1, 1'b0, 3);
        rd(16'h8004, 24'h018004, 1'b1, 1'b0, 1);
        rd(16'h8006, 24'h018006, 1'b1, 1'b0, 1);
        core.set_rep(1'b0);
        rd(16'h8008, 24'h018008, 1'b1, 1'b0, 2);
        core.set_rep(1'b1);
        rd(16'h800a, 24'h01800a, 1'b1, 1'b0, 3);
        core.set_rep(1'b0);
    endtask
    task automatic t_fault();
        core.set_page(10'h205);
        rd(16'h8123, 24'h008123, 1'b0, 1'b1, 1);
    endtask
    // Mid-run reset: page and results return to their reset values
    task automatic t_reset();
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        check(pg_q, 10'h000);
        check(rd_addr, 24'h000000);
        check(rd_ready, 1'b1);
        rd(16'h8010, 24'h000010, 1'b1, 1'b0, 2);
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Hang guard, far above the hundred or fewer cycles the reads need
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 2000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        reset = 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        t_plain();
        t_paged();
        t_repeat();
        t_fault();
        t_reset();
        finish_test();
    end
endmodule

bind paged_data_read_address_gen paged_read_sva chk (.mclk(mclk), .reset(reset), .rd_req(rd_req),
    .rd_ea(rd_ea), .repeat_active(repeat_active), .rd_ready(rd_ready), .rd_addr(rd_addr), .rd_ext(rd_ext),
    .rd_page_fault(rd_page_fault), .rd_done(rd_done), .read_page_select_register(read_page_select_register));
